// ### mmp_memory_map.v
// Address decoder for the 64 Kbyte CPU space with the port register bank
// and the 384-byte RAM held in flip-flops.
// Assumes the CPU bus master: single-cycle strobes, read data one cycle later.
`timescale 1ns/1ns
`include "mmp_consts.vh"

module mmp_memory_map #(
    parameter FLASH_KB = `MMP_FLASH_KB_MAX,
    parameter RAM_BYTES = `MMP_RAM_BYTES
) (
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // CPU bus
    input wire [15:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output wire [7:0] bus_rdata,
    // Option byte: flash sector 0 size in bytes, a static strap
    input wire [15:0] opt_sector0_bytes,
    // Flash read port, served outside this block
    output wire flash_rd,
    output wire [15:0] flash_addr,
    input wire [7:0] flash_rdata,
    // Decode status of the current address
    output wire [2:0] rgn_code,
    output wire stack_hit,
    // Port register contents
    output wire [7:0] port_a_data,
    output wire [7:0] port_a_direction,
    output wire [7:0] port_a_option,
    output wire [7:0] port_b_data,
    output wire [7:0] port_b_direction,
    output wire [7:0] port_b_option,
    output wire [7:0] port_c_data,
    output wire [7:0] port_c_direction,
    output wire [7:0] port_c_option
);

    // Flash occupies the top FLASH_KB Kbytes
    localparam [31:0] FLASH_BYTES = FLASH_KB * 1024;
    localparam [15:0] FLASH_BASE = 16'hffff - FLASH_BYTES[15:0] + 16'h0001;
    localparam [31:0] RAM_LAST_W = `MMP_RAM_BASE + RAM_BYTES - 1;
    localparam [15:0] RAM_LAST = RAM_LAST_W[15:0];

    // Read-data source for the cycle after a read
    localparam SRC_ZERO = 2'd0;
    localparam SRC_REG = 2'd1;
    localparam SRC_RAM = 2'd2;
    localparam SRC_FLASH = 2'd3;

    reg [2:0] rgn;
    reg [1:0] src_q;
    reg [7:0] reg_rd_q;
    reg [7:0] ram_rd_q;
    reg [16:0] sec0_base_q;
    wire in_reg;
    wire in_ram;
    wire in_flash;
    wire [7:0] bank_rdata;
    wire [9*8-1:0] bank_regs;
    wire [8:0] ram_idx;

    // Region compare on the whole 16-bit address, no aliasing
    assign in_reg = bus_addr <= `MMP_REG_LAST;
    assign in_ram = bus_addr >= `MMP_RAM_BASE && bus_addr <= RAM_LAST;
    assign in_flash = bus_addr >= FLASH_BASE;

    // Sector 0 base latched from the option byte; 17 bits so a size of 0 leaves only the vectors
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            sec0_base_q <= `MMP_SEC0_RST;
        end else begin
            sec0_base_q <= `MMP_SEC0_RST - {1'b0, opt_sector0_bytes};
        end
    end

    // Sector 0 always contains the vector block at the top
    always @* begin
        if (in_reg) begin
            rgn = `MMP_RGN_REG;
        end else if (in_ram) begin
            rgn = `MMP_RGN_RAM;
        end else if (in_flash) begin
            if (bus_addr >= `MMP_VECT_BASE || {1'b0, bus_addr} >= sec0_base_q) begin
                rgn = `MMP_RGN_FLASH0;
            end else begin
                rgn = `MMP_RGN_FLASH1;
            end
        end else begin
            rgn = `MMP_RGN_NONE;
        end
    end
    assign rgn_code = rgn;
    assign stack_hit = bus_addr >= `MMP_STACK_BASE && bus_addr <= `MMP_STACK_LAST;

    // Port register bank in the bottom of the register area
    mmp_port_bank #(
        .NREGS(`MMP_PORT_REGS)
    ) u_bank (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .bank_idx(bus_addr[3:0]),
        .bank_wr(bus_wr && in_reg && bus_addr[15:4] == 12'h000),
        .bank_wdata(bus_wdata),
        .bank_rdata(bank_rdata),
        .bank_regs(bank_regs)
    );

    assign port_a_data = bank_regs[`MMP_OFS_PA_DATA*8 +: 8];
    assign port_a_direction = bank_regs[`MMP_OFS_PA_DIR*8 +: 8];
    assign port_a_option = bank_regs[`MMP_OFS_PA_OPT*8 +: 8];
    assign port_b_data = bank_regs[`MMP_OFS_PB_DATA*8 +: 8];
    assign port_b_direction = bank_regs[`MMP_OFS_PB_DIR*8 +: 8];
    assign port_b_option = bank_regs[`MMP_OFS_PB_OPT*8 +: 8];
    assign port_c_data = bank_regs[`MMP_OFS_PC_DATA*8 +: 8];
    assign port_c_direction = bank_regs[`MMP_OFS_PC_DIR*8 +: 8];
    assign port_c_option = bank_regs[`MMP_OFS_PC_OPT*8 +: 8];

    // RAM in flip-flops, indexed from the RAM base; stack is its top part
    assign ram_idx = bus_addr[8:0] - 9'h080;
    reg [7:0] ram_mem [0:RAM_BYTES-1];
    always @(posedge sys_clk) begin
        if (bus_wr && in_ram) begin
            ram_mem[ram_idx] <= bus_wdata;
        end
    end

    // Read capture; reserved space reads zero though masters must avoid it
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            src_q <= SRC_ZERO;
            reg_rd_q <= 8'h00;
            ram_rd_q <= 8'h00;
        end else if (bus_rd) begin
            reg_rd_q <= (bus_addr[15:4] == 12'h000) ? bank_rdata : 8'h00;
            ram_rd_q <= in_ram ? ram_mem[ram_idx] : 8'h00;
            case (rgn)
                `MMP_RGN_REG: src_q <= SRC_REG;
                `MMP_RGN_RAM: src_q <= SRC_RAM;
                `MMP_RGN_FLASH0: src_q <= SRC_FLASH;
                `MMP_RGN_FLASH1: src_q <= SRC_FLASH;
                default: src_q <= SRC_ZERO;
            endcase
        end else begin
            src_q <= SRC_ZERO;
        end
    end

    // Flash is read with the address, its data arrives one cycle later
    assign flash_rd = bus_rd && in_flash;
    assign flash_addr = bus_addr;

    assign bus_rdata = (src_q == SRC_REG) ? reg_rd_q :
                       (src_q == SRC_RAM) ? ram_rd_q :
                       (src_q == SRC_FLASH) ? flash_rdata : 8'h00;

endmodule

// ### mmp_consts.vh
// Constants for the memory map decoder and port register bank.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef MMP_CONSTS_VH
`define MMP_CONSTS_VH

// Address space
`define MMP_ADDR_W 16
`define MMP_DATA_W 8

// Region bounds
`define MMP_REG_BASE 16'h0000
`define MMP_REG_LAST 16'h007f
`define MMP_RAM_BASE 16'h0080
`define MMP_RAM_LAST 16'h01ff
`define MMP_RAM_BYTES 384
`define MMP_STACK_BASE 16'h0180
`define MMP_STACK_LAST 16'h01ff
`define MMP_VECT_BASE 16'hffe0
`define MMP_FLASH_TOP 16'hffff
// Sector 0 base while in reset: one past the top, so only the vectors
`define MMP_SEC0_RST 17'h10000

// Flash size in Kbytes, smallest and largest variant
`define MMP_FLASH_KB_MIN 4
`define MMP_FLASH_KB_MAX 8

// Port register offsets
`define MMP_OFS_PA_DATA 16'h0000
`define MMP_OFS_PA_DIR 16'h0001
`define MMP_OFS_PA_OPT 16'h0002
`define MMP_OFS_PB_DATA 16'h0003
`define MMP_OFS_PB_DIR 16'h0004
`define MMP_OFS_PB_OPT 16'h0005
`define MMP_OFS_PC_DATA 16'h0006
`define MMP_OFS_PC_DIR 16'h0007
`define MMP_OFS_PC_OPT 16'h0008
`define MMP_PORT_REGS 9

// Reset values
`define MMP_RST_PA_DATA 8'h00
`define MMP_RST_PA_DIR 8'h00
`define MMP_RST_PA_OPT 8'h00
`define MMP_RST_PB_DATA 8'h00
`define MMP_RST_PB_DIR 8'h00
`define MMP_RST_PB_OPT 8'h00
`define MMP_RST_PC_DATA 8'h00
`define MMP_RST_PC_DIR 8'h00
`define MMP_RST_PC_OPT 8'h08

// Region codes
`define MMP_RGN_NONE 3'h0
`define MMP_RGN_REG 3'h1
`define MMP_RGN_RAM 3'h2
`define MMP_RGN_FLASH1 3'h3
`define MMP_RGN_FLASH0 3'h4

`endif

// ### mmp_port_bank.v
// Bank of nine 8-bit port registers (data, direction, option per port).
// Assumes one write strobe per cycle, already decoded to the register area.
`timescale 1ns/1ns
`include "mmp_consts.vh"

module mmp_port_bank #(
    parameter NREGS = `MMP_PORT_REGS
) (
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Access from the decoder
    input wire [3:0] bank_idx,
    input wire bank_wr,
    input wire [7:0] bank_wdata,
    output wire [7:0] bank_rdata,
    // Flat register contents, index 0 in the low byte
    output wire [NREGS*8-1:0] bank_regs
);

    // Per-register reset values, index 8 holds the odd one out
    function [7:0] rst_val;
        input integer idx;
        begin
            case (idx)
                0: rst_val = `MMP_RST_PA_DATA;
                1: rst_val = `MMP_RST_PA_DIR;
                2: rst_val = `MMP_RST_PA_OPT;
                3: rst_val = `MMP_RST_PB_DATA;
                4: rst_val = `MMP_RST_PB_DIR;
                5: rst_val = `MMP_RST_PB_OPT;
                6: rst_val = `MMP_RST_PC_DATA;
                7: rst_val = `MMP_RST_PC_DIR;
                8: rst_val = `MMP_RST_PC_OPT;
                default: rst_val = 8'h00;
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < NREGS; g = g + 1) begin : g_reg
            reg [7:0] val_q;
            // Write lands at the edge that ends the strobe cycle
            always @(posedge sys_clk) begin
                if (sys_rst) begin
                    val_q <= rst_val(g);
                end else if (bank_wr && {28'h0000000, bank_idx} == g) begin
                    val_q <= bank_wdata;
                end
            end
            assign bank_regs[g*8 +: 8] = val_q;
        end
    endgenerate

    // Unused indices read as zero
    assign bank_rdata = (bank_idx < NREGS) ? bank_regs[bank_idx*8 +: 8] : 8'h00;

endmodule

// ### mmp_flash_model.sv
// Behavioural program flash seen from the decoder's flash read port.
// Assumes flash_rd is high only in the read cycle of a flash access.
`timescale 1ns/1ns
module mmp_flash_model (
    // Clock
    input wire sys_clk,
    // Read port
    input wire flash_rd,
    input wire [15:0] flash_addr,
    output reg [7:0] flash_rdata
);
    initial flash_rdata = 8'h00;
    // Data a cycle after the request; otherwise toggles so stale data never matches
    always @(posedge sys_clk) begin
        flash_rdata <= flash_rd ? (flash_addr[15:8] ^ flash_addr[7:0]) : ~flash_rdata;
    end
endmodule

// ### mmp_monitor.sv
// Port checker for the memory map decoder and port registers.
// Assumes binding onto mmp_memory_map with one clock and sync reset.
`timescale 1ns/1ns
module mmp_monitor #(
    parameter FLASH_KB = 8
) (
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Bus, option and flash data
    input wire [15:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_rdata,
    input wire [15:0] opt_sector0_bytes,
    input wire [7:0] flash_rdata,
    // Decode and registers
    input wire [2:0] rgn_code,
    input wire stack_hit,
    input wire [7:0] port_a_data,
    input wire [7:0] port_c_option
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Lowest flash address of this variant
    localparam int FLOOR = 65536 - FLASH_KB * 1024;
    // Read of a port register returns its value one cycle later
    rd_port_a: assert property (
        bus_rd && bus_addr == 16'h0000 |=> bus_rdata == $past(port_a_data)) else $error("port read mismatch");
    wr_port_a: assert property (
        bus_wr && bus_addr == 16'h0008 |=> port_c_option == $past(bus_wdata)) else $error("port write lost");
    // Reset values checked while reset is still high, so no disable here
    rst_value_a: assert property (disable iff (1'b0)
        sys_rst |=> port_c_option == 8'h08 && port_a_data == 8'h00) else $error("bad reset value");
    stack_win_a: assert property (
        stack_hit == (bus_addr >= 16'h0180 && bus_addr <= 16'h01ff)) else $error("stack decode");
    reg_area_a: assert property (
        bus_addr <= 16'h007f |-> rgn_code == 3'h1) else $error("register area decode");
    ram_area_a: assert property (
        bus_addr >= 16'h0080 && bus_addr <= 16'h01ff |-> rgn_code == 3'h2) else $error("ram decode");
    flash_sect_a: assert property (
        int'(bus_addr) >= FLOOR && $stable(opt_sector0_bytes) |-> rgn_code == ((bus_addr >= 16'hffe0
        || int'(bus_addr) >= 65536 - int'(opt_sector0_bytes)) ? 3'h4 : 3'h3)) else $error("flash decode");
    flash_data_a: assert property (
        bus_rd && rgn_code >= 3'h3 |=> bus_rdata == flash_rdata) else $error("flash data");
    rdata_idle_a: assert property (
        !bus_rd |=> bus_rdata == 8'h00) else $error("read data outside read slot");
    // Main scenarios
    cover property (bus_wr && bus_addr == 16'h0008);
    cover property (bus_rd && rgn_code == 3'h4);
    cover property (bus_rd && stack_hit);
endmodule
bind mmp_memory_map mmp_monitor #(.FLASH_KB(FLASH_KB)) u_mmp_monitor (.sys_clk(sys_clk), .sys_rst(sys_rst), 
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .opt_sector0_bytes(opt_sector0_bytes), .flash_rdata(flash_rdata), .rgn_code(rgn_code),
    .stack_hit(stack_hit), .port_a_data(port_a_data), .port_c_option(port_c_option));

// ### mmp_memory_map_tb.sv
// Self-checking bench for the memory map decoder and port registers.
// Assumes the flash model on the flash port and an 8 Kbyte variant.
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module mmp_memory_map_tb;
    reg sys_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [15:0] bus_addr = 16'h0000;
    reg [7:0] bus_wdata = 8'h00;
    reg bus_wr = 1'b0;
    reg bus_rd = 1'b0;
    reg [15:0] opt_sector0_bytes = 16'h1000;
    wire [7:0] bus_rdata, flash_rdata;
    wire [71:0] port_q;
    wire [15:0] flash_addr;
    wire [2:0] rgn_code;
    wire flash_rd, stack_hit;
    int n_checks = 0;
    int n_mismatch = 0;
    int i;
    // 125 MHz
    always #4 sys_clk = ~sys_clk;
    mmp_memory_map u_mmp_memory_map (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .opt_sector0_bytes(opt_sector0_bytes), .flash_rd(flash_rd), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata), .rgn_code(rgn_code), .stack_hit(stack_hit), .port_a_data(port_q[7:0]),
        .port_a_direction(port_q[15:8]), .port_a_option(port_q[23:16]), .port_b_data(port_q[31:24]),
        .port_b_direction(port_q[39:32]), .port_b_option(port_q[47:40]), .port_c_data(port_q[55:48]),
        .port_c_direction(port_q[63:56]), .port_c_option(port_q[71:64]));
    mmp_flash_model u_mmp_flash_model (.sys_clk(sys_clk), .flash_rd(flash_rd), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata));
    // Write leaves the strobe up; the next call's edge takes it, so writes run back to back
    task wr(input [15:0] a, input [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_rd <= 1'b0;
        bus_wr <= 1'b1;
    endtask
    task rd(input [15:0] a, input [7:0] e);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wr <= 1'b0;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1;
        `CHK(bus_rdata, e)
    endtask
    // Address and option strap only, no strobe, so reserved space is decoded but never accessed
    task probe(input [15:0] a, input [15:0] o, input [2:0] e);
        @(posedge sys_clk);
        bus_addr <= a;
        opt_sector0_bytes <= o;
        @(posedge sys_clk);
        #1;
        `CHK(rgn_code, e)
    endtask
    task rst;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        sys_rst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        summarize;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 9; i++) rd(i[15:0], (i == 8) ? 8'h08 : 8'h00);
        $display("test reset_values done");
        for (i = 0; i < 9; i++) wr(i[15:0], 8'ha0 + i[7:0]);
        for (i = 0; i < 9; i++) rd(i[15:0], 8'ha0 + i[7:0]);
        for (i = 0; i < 9; i++) `CHK(port_q[i*8 +: 8], 8'ha0 + i[7:0])
        wr(16'h0008, 8'h55);
        rd(16'h0008, 8'h55);
        $display("test port_write_read done");
        wr(16'h000c, 8'hff);
        wr(16'he000, 8'hff);
        rd(16'h000c, 8'h00);
        rd(16'he000, 8'he0);
        rd(16'h0000, 8'ha0);
        $display("test unmapped done");
        wr(16'h0080, 8'h11);
        wr(16'h01ff, 8'h22);
        rd(16'h01ff, 8'h22);
        `CHK(stack_hit, 1'b1)
        rd(16'h0080, 8'h11);
        `CHK(stack_hit, 1'b0)
        $display("test ram_stack done");
        probe(16'hdfff, 16'h1000, 3'h0);
        `CHK(bus_rdata, 8'h00)
        rd(16'he000, 8'he0);
        `CHK(rgn_code, 3'h3)
        rd(16'hf000, 8'hf0);
        `CHK(rgn_code, 3'h4)
        rd(16'hfffe, 8'h01);
        `CHK(rgn_code, 3'h4)
        probe(16'hf000, 16'h0000, 3'h3);
        probe(16'hffe0, 16'h0000, 3'h4);
        probe(16'hffdf, 16'h0000, 3'h3);
        $display("test flash done");
        wr(16'h0000, 8'h77);
        rst;
        rd(16'h0000, 8'h00);
        rd(16'h0008, 8'h08);
        $display("test mid_reset done");
        summarize;
    end
endmodule
